// ### disk_cs2_cfg.svh
// Constants for the controller status two low bit bank
`ifndef DISK_CS2_CFG_SVH
`define DISK_CS2_CFG_SVH

// Register width and field positions
`define CS2_WIDTH          16
`define CS2_MISSING_MEM    11
`define CS2_PROGRAM_ERR    10
`define CS2_MISSED_XFER    9
`define CS2_DRIVE_PARITY   8
`define CS2_OUT_READY      7
`define CS2_IN_READY       6
`define CS2_CTRL_CLEAR     5
`define CS2_PARITY_TEST    4
`define CS2_ADDR_INHIBIT   3
`define CS2_UNIT_MSB       2
`define CS2_UNIT_LSB       0
`define CS2_UNIT_W         3

// Reset values
`define CS2_UNIT_RST       3'h0
`define CS2_ADDR_RST       16'h0000
`define CS2_RD_RST         16'h0040

// Timing
`define MCLK_MHZ           10
`define MEM_TIMEOUT_US     10
`define MEM_TIMEOUT_CYC    (`MEM_TIMEOUT_US * `MCLK_MHZ)
`define WAIT_CNT_W         8
`define ADDR_STEP          16'h0002

`endif

// ### disk_cs2_pkg.sv
// Types for the controller status two low bit bank
`default_nettype none
`include "disk_cs2_cfg.svh"

package disk_cs2_pkg;

    // Transfer events reported by the data path
    typedef struct packed {
        logic header_miss;
        logic sector_miss;
        logic buffer_stuck;
    } xfer_evt_t;

    // Complete state of the bank
    typedef struct packed {
        logic                      missing_memory_flag;
        logic                      program_error_flag;
        logic                      missed_transfer_flag;
        logic                      transfer_error_summary;
        logic                      parity_test_bit;
        logic                      address_increment_inhibit;
        logic [`CS2_UNIT_W-1:0]    unit_select;
        logic                      drive_clear;
        logic [`WAIT_CNT_W-1:0]    wait_cnt;
        logic [`CS2_WIDTH-1:0]     bus_address;
        logic [`CS2_WIDTH-1:0]     rd_data;
    } cs2_state_t;

endpackage
`default_nettype wire

// ### disk_cs2_bank.sv
// Low twelve bits of controller status two with bus address register
`timescale 1ns/10ps
`default_nettype none
`include "disk_cs2_cfg.svh"

module disk_cs2_bank #(
    parameter int TIMEOUT_CYC = `MEM_TIMEOUT_CYC
) (
    input  wire logic                         mclk,
    input  wire logic                         sys_rst,
    input  wire logic                         bus_init,
    input  wire logic                         error_clear,
    input  wire logic                         go_load,
    input  wire logic                         xfer_busy,
    input  wire logic                         wr_en,
    input  wire logic [`CS2_WIDTH-1:0]        wr_data,
    input  wire logic                         msyn,
    input  wire logic                         ssyn,
    input  wire logic                         word_done,
    input  wire logic                         addr_load,
    input  wire logic [`CS2_WIDTH-1:0]        addr_data,
    input  wire logic                         buffer_full,
    input  wire disk_cs2_pkg::xfer_evt_t      xfer_evt,
    output logic [`CS2_WIDTH-1:0]             rd_data,
    output logic [`CS2_WIDTH-1:0]             bus_address,
    output logic [`CS2_UNIT_W-1:0]            unit_select,
    output logic                              drive_clear,
    output logic                              missing_memory_flag,
    output logic                              program_error_flag,
    output logic                              missed_transfer_flag,
    output logic                              transfer_error_summary
);
    import disk_cs2_pkg::*;

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    localparam logic [`WAIT_CNT_W-1:0] LIMIT = TIMEOUT_CYC[`WAIT_CNT_W-1:0];
    localparam logic [`WAIT_CNT_W-1:0] LAST  = LIMIT - 8'h01;

    // The watchdog counter is eight bits wide and needs two states at least
    if (TIMEOUT_CYC < 2 || TIMEOUT_CYC > 255) begin : g_bad_timeout
        $error("TIMEOUT_CYC must lie in 2..255");
    end

    // ****************************************************************
    // Decode helpers
    // ****************************************************************
    function automatic logic [`CS2_WIDTH-1:0] pack_read(
        input cs2_state_t s,
        input logic       out_ready
    );
        logic [`CS2_WIDTH-1:0] v;
        v = '0;
        v[`CS2_MISSING_MEM]  = s.missing_memory_flag;
        v[`CS2_PROGRAM_ERR]  = s.program_error_flag;
        v[`CS2_MISSED_XFER]  = s.missed_transfer_flag;
        v[`CS2_DRIVE_PARITY] = 1'b0;
        v[`CS2_OUT_READY]    = out_ready;
        v[`CS2_IN_READY]     = 1'b1;
        v[`CS2_CTRL_CLEAR]   = 1'b0;
        v[`CS2_PARITY_TEST]  = s.parity_test_bit;
        v[`CS2_ADDR_INHIBIT] = s.address_increment_inhibit;
        v[`CS2_UNIT_MSB:`CS2_UNIT_LSB] = s.unit_select;
        return v;
    endfunction

    // ****************************************************************
    // State
    // ****************************************************************
    cs2_state_t state_r;
    cs2_state_t state_nxt;

    logic waiting;
    logic timeout_evt;
    logic ctl_clear;
    logic init_any;
    logic missed_evt;
    logic busy_start;
    logic address_increment_inhibit_q;

    assign waiting     = xfer_busy && msyn && !ssyn;
    assign timeout_evt = waiting && (state_r.wait_cnt == LAST);
    assign ctl_clear   = wr_en && wr_data[`CS2_CTRL_CLEAR];
    assign init_any    = bus_init || ctl_clear;
    assign missed_evt  = xfer_evt.header_miss || xfer_evt.sector_miss ||
                         xfer_evt.buffer_stuck;
    assign busy_start  = go_load && xfer_busy;
    assign address_increment_inhibit_q = state_r.address_increment_inhibit;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        state_nxt = state_r;

        // Memory answer watchdog; holds at limit until sync drops
        if (waiting) begin
            if (state_r.wait_cnt != LIMIT) begin
                state_nxt.wait_cnt = state_r.wait_cnt + 8'h01;
            end
        end else begin
            state_nxt.wait_cnt = '0;
        end

        // Error flags: every set wins over a clear in the same cycle
        if (init_any || error_clear || go_load) begin
            state_nxt.missing_memory_flag  = 1'b0;
            state_nxt.missed_transfer_flag = 1'b0;
        end
        if (init_any || error_clear) begin
            state_nxt.program_error_flag = 1'b0;
        end
        if (timeout_evt) begin
            state_nxt.missing_memory_flag = 1'b1;
        end
        if (busy_start) begin
            state_nxt.program_error_flag = 1'b1;
        end
        if (missed_evt) begin
            state_nxt.missed_transfer_flag = 1'b1;
        end
        state_nxt.transfer_error_summary = state_nxt.missing_memory_flag |
                                           state_nxt.program_error_flag |
                                           state_nxt.missed_transfer_flag;

        // Writable fields
        if (wr_en) begin
            state_nxt.parity_test_bit = wr_data[`CS2_PARITY_TEST];
            state_nxt.unit_select =
                wr_data[`CS2_UNIT_MSB:`CS2_UNIT_LSB];
            if (!xfer_busy) begin
                state_nxt.address_increment_inhibit =
                    wr_data[`CS2_ADDR_INHIBIT];
            end
        end
        if (init_any) begin
            state_nxt.parity_test_bit           = 1'b0;
            state_nxt.address_increment_inhibit = 1'b0;
            state_nxt.unit_select               = `CS2_UNIT_RST;
        end

        // Controller clear reaches every drive as a one cycle pulse
        state_nxt.drive_clear = ctl_clear;

        // Bus address register
        if (addr_load) begin
            state_nxt.bus_address = addr_data;
        end else if (timeout_evt) begin
            state_nxt.bus_address = state_r.bus_address + `ADDR_STEP;
        end else if (word_done && !state_r.address_increment_inhibit) begin
            state_nxt.bus_address = state_r.bus_address + `ADDR_STEP;
        end

        state_nxt.rd_data = pack_read(state_nxt, buffer_full);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_r <= '{
                missing_memory_flag:       1'b0,
                program_error_flag:        1'b0,
                missed_transfer_flag:      1'b0,
                transfer_error_summary:    1'b0,
                parity_test_bit:           1'b0,
                address_increment_inhibit: 1'b0,
                unit_select:               `CS2_UNIT_RST,
                drive_clear:               1'b0,
                wait_cnt:                  '0,
                bus_address:               `CS2_ADDR_RST,
                rd_data:                   `CS2_RD_RST
            };
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign rd_data                = state_r.rd_data;
    assign bus_address            = state_r.bus_address;
    assign unit_select            = state_r.unit_select;
    assign drive_clear            = state_r.drive_clear;
    assign missing_memory_flag    = state_r.missing_memory_flag;
    assign program_error_flag     = state_r.program_error_flag;
    assign missed_transfer_flag   = state_r.missed_transfer_flag;
    assign transfer_error_summary = state_r.transfer_error_summary;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_wait_run;
        waiting && !addr_load;
    endsequence

    sequence s_timeout;
        s_wait_run ##0 (state_r.wait_cnt == LAST);
    endsequence

    sequence s_quiet_errors;
        !timeout_evt && !busy_start && !missed_evt;
    endsequence

    property p_timeout_flag;
        s_timeout |=> missing_memory_flag && transfer_error_summary;
    endproperty

    property p_no_early_flag;
        (waiting && state_r.wait_cnt < LAST && !missing_memory_flag)
            ##0 s_quiet_errors ##0 (!init_any)
            |=> !missing_memory_flag;
    endproperty

    a_timeout_sets_flag: assert property (p_timeout_flag)
        else $error("memory timeout did not set flag");

    a_timeout_no_early: assert property (p_no_early_flag)
        else $error("memory flag set before timeout");

    a_addr_plus_two: assert property (
        s_timeout |=> bus_address == $past(bus_address) + `ADDR_STEP)
        else $error("bus address not advanced by two on timeout");

    a_go_clears_flags: assert property (
        (go_load || error_clear) ##0 s_quiet_errors
            |=> !missing_memory_flag && !missed_transfer_flag)
        else $error("memory or missed flag survived clear");

    a_busy_start_err: assert property (
        busy_start |=> program_error_flag && transfer_error_summary)
        else $error("start while busy missed program error");

    a_prog_err_holds: assert property (
        program_error_flag && !init_any && !error_clear
            |=> program_error_flag)
        else $error("program error lost without clear");

    a_missed_sets: assert property (
        missed_evt |=> missed_transfer_flag && transfer_error_summary)
        else $error("missed transfer event not flagged");

    a_fixed_bits: assert property (
        ##1 (rd_data[`CS2_DRIVE_PARITY] == 1'b0 &&
             rd_data[`CS2_IN_READY] == 1'b1 &&
             rd_data[`CS2_CTRL_CLEAR] == 1'b0 &&
             rd_data[15:12] == 4'h0))
        else $error("fixed read bits wrong");

    a_out_ready: assert property (
        1'b1 |=> rd_data[`CS2_OUT_READY] == $past(buffer_full))
        else $error("output ready does not follow buffer");

    a_clear_pulse: assert property (
        ctl_clear |=> drive_clear ##1 !drive_clear || $past(ctl_clear))
        else $error("controller clear pulse missing");

    a_parity_stored: assert property (
        wr_en && !init_any
            |=> rd_data[`CS2_PARITY_TEST] == $past(wr_data[`CS2_PARITY_TEST]))
        else $error("parity test bit not stored");

    a_inhibit_hold: assert property (
        address_increment_inhibit_q && word_done && !addr_load && !timeout_evt
            |=> $stable(bus_address))
        else $error("bus address moved while inhibited");

    a_inhibit_locked: assert property (
        xfer_busy && !init_any |=> $stable(address_increment_inhibit_q))
        else $error("inhibit bit changed during transfer");

    a_init_fields: assert property (
        init_any |=> !address_increment_inhibit_q &&
                     !rd_data[`CS2_PARITY_TEST] && unit_select == 3'h0)
        else $error("init did not clear writable fields");

    a_unit_write: assert property (
        wr_en && !init_any
            |=> unit_select == $past(wr_data[`CS2_UNIT_MSB:`CS2_UNIT_LSB]))
        else $error("unit select not written");

    a_summary_or: assert property (
        transfer_error_summary == (missing_memory_flag ||
                                   program_error_flag ||
                                   missed_transfer_flag))
        else $error("summary is not OR of error flags");

    // Watchdog counter and bus address register
    sequence s_addr_step;
        word_done && !address_increment_inhibit_q && !addr_load &&
            !timeout_evt;
    endsequence

    a_wait_bounded: assert property (
        state_r.wait_cnt <= LIMIT)
        else $error("watchdog count beyond its limit");

    a_wait_counts: assert property (
        waiting && state_r.wait_cnt != LIMIT
            |=> state_r.wait_cnt == $past(state_r.wait_cnt) + 8'h01)
        else $error("watchdog did not count a waiting cycle");

    a_wait_restart: assert property (
        !waiting |=> state_r.wait_cnt == '0)
        else $error("watchdog not restarted after answer");

    a_addr_steps: assert property (
        s_addr_step |=> bus_address == $past(bus_address) + `ADDR_STEP)
        else $error("bus address did not step by two");

    a_addr_loaded: assert property (
        addr_load |=> bus_address == $past(addr_data))
        else $error("bus address load lost");

    a_unit_no_disturb: assert property (
        wr_en && xfer_busy && !addr_load && !word_done && !timeout_evt
            |=> $stable(bus_address))
        else $error("status write disturbed the transfer address");

    // Error flag clearing and the drive clear pulse source
    a_init_clears_errs: assert property (
        init_any ##0 s_quiet_errors
            |=> !missing_memory_flag && !program_error_flag &&
                !missed_transfer_flag)
        else $error("init left an error flag set");

    a_prog_err_clear: assert property (
        error_clear && !busy_start |=> !program_error_flag)
        else $error("error clear left program error set");

    a_missed_holds: assert property (
        missed_transfer_flag && !init_any && !error_clear && !go_load
            |=> missed_transfer_flag)
        else $error("missed transfer flag lost without clear");

    a_clear_source: assert property (
        drive_clear |-> $past(ctl_clear))
        else $error("drive clear pulse without a clear write");

endmodule
`default_nettype wire

// ### host_mem_model.sv
// Host memory that answers the master sync, or stays silent when absent
`timescale 1ns/10ps
`default_nettype none

module host_mem_model (
    input  wire logic mclk,
    input  wire logic msyn,
    input  wire logic present,
    output logic      ssyn
);
    // *********************************
    // Slave sync
    // *********************************
    // An absent location never answers, so the watchdog must run out
    always_ff @(posedge mclk) begin
        ssyn <= msyn && present;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the controller status two low bit bank
`timescale 1ns/10ps
`default_nettype none
`include "disk_cs2_cfg.svh"

module tb_top;
    import disk_cs2_pkg::*;

    typedef struct packed {
        logic [15:0] wd;
        logic        busy;
        logic [15:0] exp;
    } row_t;

    logic        mclk, sys_rst, bus_init, error_clear, go_load, xfer_busy;
    logic        wr_en, msyn, ssyn, word_done, addr_load, buffer_full;
    logic        present, drive_clear, mem_err, prog_err, miss_err, err_sum;
    logic [15:0] wr_data, addr_data, rd_data, bus_address;
    logic [2:0]  unit_select;
    xfer_evt_t   xfer_evt;
    int          bad_count, check_count;
    row_t        rows [5] = '{
        '{16'h0017, 1'b0, 16'h0057}, '{16'h0008, 1'b0, 16'h0048},
        '{16'h0005, 1'b1, 16'h004d}, '{16'hff12, 1'b0, 16'h0052},
        '{16'h0037, 1'b0, 16'h0040}};

    disk_cs2_bank #(.TIMEOUT_CYC(4)) u_disk_cs2_bank (
        .mclk(mclk), .sys_rst(sys_rst), .bus_init(bus_init),
        .error_clear(error_clear), .go_load(go_load),
        .xfer_busy(xfer_busy), .wr_en(wr_en), .wr_data(wr_data),
        .msyn(msyn), .ssyn(ssyn), .word_done(word_done),
        .addr_load(addr_load), .addr_data(addr_data),
        .buffer_full(buffer_full), .xfer_evt(xfer_evt),
        .rd_data(rd_data), .bus_address(bus_address),
        .unit_select(unit_select), .drive_clear(drive_clear),
        .missing_memory_flag(mem_err), .program_error_flag(prog_err),
        .missed_transfer_flag(miss_err),
        .transfer_error_summary(err_sum));

    host_mem_model u_host_mem_model (
        .mclk(mclk), .msyn(msyn), .present(present), .ssyn(ssyn));

    // *********************************
    // Clock, checks and verdict
    // *********************************
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask

    task automatic wr(input logic [15:0] d, input logic busy);
        wr_data = d;
        xfer_busy = busy;
        pulse(wr_en);
    endtask

    initial begin
        #200us;
        bad_count++;
        results();
    end

    // *********************************
    // Stimulus
    // *********************************
    initial begin
        {bus_init, error_clear, go_load, xfer_busy, wr_en, msyn} = '0;
        {word_done, addr_load, buffer_full, present} = '0;
        {wr_data, addr_data} = '0;
        xfer_evt = '0;
        bad_count = 0;
        check_count = 0;
        sys_rst = 1'b1;
        repeat (3) @(negedge mclk);
        sys_rst = 1'b0;
        check(rd_data, 16'h0040);
        check({mem_err, prog_err, miss_err, err_sum}, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            wr(rows[i].wd, rows[i].busy);
            check(rd_data, rows[i].exp);
            check(unit_select, rows[i].exp[2:0]);
            check(drive_clear, rows[i].wd[5]);
            @(negedge mclk);
            check(drive_clear, 16'h0000);
        end
        xfer_busy = 1'b0;
        @(negedge mclk);
        check(drive_clear, 16'h0000);
        buffer_full = 1'b1;
        @(negedge mclk);
        check(rd_data[7], 16'h0001);
        buffer_full = 1'b0;
        @(negedge mclk);
        check(rd_data[7], 16'h0000);
        addr_data = 16'h1000;
        pulse(addr_load);
        pulse(word_done);
        check(bus_address, 16'h1002);
        wr(16'h0008, 1'b0);
        pulse(word_done);
        check(bus_address, 16'h1002);
        wr(16'h0000, 1'b0);
        addr_data = 16'h2000;
        pulse(addr_load);
        present = 1'b1;
        xfer_busy = 1'b1;
        msyn = 1'b1;
        repeat (8) @(negedge mclk);
        check(mem_err, 16'h0000);
        msyn = 1'b0;
        present = 1'b0;
        @(negedge mclk);
        msyn = 1'b1;
        repeat (3) @(negedge mclk);
        check(mem_err, 16'h0000);
        @(negedge mclk);
        check({mem_err, err_sum}, 16'h0003);
        check(bus_address, 16'h2002);
        msyn = 1'b0;
        pulse(go_load);
        check({mem_err, prog_err, err_sum}, 16'h0003);
        xfer_busy = 1'b0;
        @(negedge mclk);
        pulse(go_load);
        check({mem_err, prog_err, err_sum}, 16'h0003);
        pulse(error_clear);
        check({prog_err, err_sum}, 16'h0000);
        wr(16'h0006, 1'b0);
        for (int i = 0; i < 3; i++) begin
            xfer_evt = xfer_evt_t'(3'h1 << i);
            @(negedge mclk);
            xfer_evt = '0;
            check({miss_err, err_sum}, 16'h0003);
            if (i == 0) begin
                pulse(error_clear);
            end else if (i == 1) begin
                pulse(go_load);
            end else begin
                pulse(bus_init);
            end
            check({miss_err, err_sum}, 16'h0000);
        end
        check(rd_data, 16'h0040);
        // Mid-run reset, then a write on the first edge after it
        wr(16'h001d, 1'b0);
        check(rd_data, 16'h005d);
        sys_rst = 1'b1;
        @(negedge mclk);
        sys_rst = 1'b0;
        check(rd_data, 16'h0040);
        check(bus_address, 16'h0000);
        wr(16'h0013, 1'b0);
        check(rd_data, 16'h0053);
        results();
    end
endmodule
`default_nettype wire
